// ==== design/spl_defines.svh ====
// shared constants for the serial program loader
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH
`define SPL_WORD_BITS 8
`define SPL_MIN_WORD_BITS 3
`define SPL_MAX_WORD_BITS 16
`define SPL_INSTR_BITS 24
`define SPL_ADDR_BITS 14
`define SPL_VECTOR_FIRST 14'h0000
`define SPL_VECTOR_LAST 14'h001c
`define SPL_LOADER_WORDS 14'h0056
`define SPL_CODE_START 14'h0073
`define SPL_HOST_DIV 4
`endif

// ==== design/spl_host.sv ====
// host end: drives serial clock, frame sync and data, byte per frame
`include "spl_defines.svh"
module spl_host
  import spl_pkg::*;
(
  input wire logic I_CLK, // system clock
  input wire logic I_SYS_RST, // synchronous reset, high
  input wire logic I_VALID, // byte offered
  input wire logic [7:0] I_DATA, // byte to send
  output logic O_READY, // byte taken this cycle
  output logic O_BUSY, // frame in progress
  spl_link_if.host link // serial link
);
  localparam int DIV = `SPL_HOST_DIV;
  spl_host_state_t state;
  logic [3:0] div_cnt;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic sclk;
  logic rise;
  logic fall;
  assign fall = (div_cnt == 4'(DIV - 1)) && sclk;
  assign rise = (div_cnt == 4'(DIV - 1)) && !sclk;
  assign O_READY = (state == SPL_H_IDLE) && I_VALID && fall;
  assign O_BUSY = (state != SPL_H_IDLE);
  // clock runs slowly, well under the device rate
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST || div_cnt == 4'(DIV - 1))
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      sclk <= 1'b0;
    else if (rise || fall)
      sclk <= ~sclk; // RULE4 RULE5
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      state <= SPL_H_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      link.rfs <= 1'b0;
      link.dr <= 1'b0;
    end
    else if (fall)
    begin
      case (state)
        SPL_H_IDLE:
        begin
          link.rfs <= 1'b0;
          if (I_VALID)
          begin
            shreg <= I_DATA; // RULE1 RULE2
            state <= SPL_H_LOAD;
          end
        end
        SPL_H_LOAD:
        begin
          // normal framing: sync stands one bit ahead of the msb
          link.rfs <= 1'b1; // RULE4
          bit_cnt <= 4'h0;
          state <= SPL_H_SHIFT;
        end
        SPL_H_SHIFT:
        begin
          link.rfs <= 1'b0;
          if (bit_cnt == 4'(`SPL_WORD_BITS))
            state <= SPL_H_END;
          else
          begin
            link.dr <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        SPL_H_END:
          state <= SPL_H_IDLE;
        default:
          state <= SPL_H_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk;
endmodule : spl_host

// ==== design/spl_link_if.sv ====
// serial link between host and loader
interface spl_link_if;
  logic sclk;
  logic rfs;
  logic dr;
  modport host (output sclk, output rfs, output dr);
  modport device (input sclk, input rfs, input dr);
endinterface : spl_link_if

// ==== design/spl_loader.sv ====
// device end: receives bytes and writes 24-bit program words
// Overview of operation
// (RULE1) count arrives as two bytes, combined
// (RULE2) instruction bytes high, middle, low order
// (RULE3) word is upper assembly plus low holding
// (RULE4) host makes clock and frame sync
// (RULE5) host clock no faster than device rate
// (RULE6) receiver takes 3 to 16 bits, set 8
// (RULE7) one byte per receive-complete event
// (RULE8) count decremented after each written word
// (RULE9) consecutive addresses after the resident loader
// (RULE10) count done: stop, start loaded code
// (RULE11) vector area never written
// (RULE12) resident loader words never overwritten
// (RULE13) byte position wraps after third byte
`include "spl_defines.svh"
module spl_loader
  import spl_pkg::*;
#(
  parameter int WORD_BITS = `SPL_WORD_BITS
)
(
  input wire logic I_CLK, // system clock
  input wire logic I_SYS_RST, // synchronous reset, high
  spl_link_if.device link, // serial link
  output logic O_PM_WE, // program memory write strobe
  output logic [`SPL_ADDR_BITS-1:0] O_PM_ADDR, // write address
  output logic [`SPL_INSTR_BITS-1:0] O_PM_DATA, // write data
  output logic O_START, // pulse: execute loaded code
  output logic [`SPL_ADDR_BITS-1:0] O_START_ADDR, // start address
  output logic O_DONE // download finished
);
  localparam logic [4:0] WLEN = 5'(WORD_BITS); // RULE6
  spl_dev_state_t state;
  logic [2:0] sclk_s;
  logic [1:0] rfs_s;
  logic [1:0] dr_s;
  logic sclk_rise;
  logic active;
  logic [4:0] bit_cnt;
  logic [15:0] rx_shift;
  logic rx_done;
  logic [7:0] rx_byte;
  logic [1:0] byte_pos;
  logic [7:0] count_hi;
  logic [15:0] remaining;
  logic [15:0] upper_word_assembly;
  logic [7:0] low_byte_holding_reg;
  logic [`SPL_ADDR_BITS-1:0] addr;
  logic [`SPL_ADDR_BITS-1:0] next_addr;
  logic write_now;
  // link pins pass two flops; third sclk stage feeds edge detect only
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      sclk_s <= 3'h0;
      rfs_s <= 2'h0;
      dr_s <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      rfs_s <= {rfs_s[0], link.rfs};
      dr_s <= {dr_s[0], link.dr};
    end
  end
  assign sclk_rise = sclk_s[1] && !sclk_s[2];
  // normal framing: sync sampled one bit before first data bit
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      active <= 1'b0;
      bit_cnt <= 5'h0;
      rx_shift <= 16'h0000;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (sclk_rise)
      begin
        if (!active && rfs_s[1] && state != SPL_DONE) // RULE4 RULE10
        begin
          active <= 1'b1;
          bit_cnt <= 5'h0;
        end
        else if (active)
        begin
          rx_shift <= {rx_shift[14:0], dr_s[1]};
          if (bit_cnt == WLEN - 5'h1)
          begin
            active <= 1'b0;
            rx_done <= 1'b1; // RULE7
          end
          bit_cnt <= bit_cnt + 5'h1;
        end
      end
    end
  end
  assign rx_byte = rx_shift[7:0];
  assign write_now = rx_done && state == SPL_INSTR && byte_pos == 2'h2;
  // a wrapped address skips vector area and resident loader
  always_comb
  begin
    next_addr = addr + 14'h0001; // RULE9
    if (next_addr < `SPL_CODE_START) // RULE11 RULE12
      next_addr = `SPL_CODE_START;
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      state <= SPL_CNT_HI;
      count_hi <= 8'h00;
      remaining <= 16'h0000;
      upper_word_assembly <= 16'h0000;
      low_byte_holding_reg <= 8'h00;
    end
    else if (rx_done)
    begin
      case (state)
        SPL_CNT_HI:
        begin
          count_hi <= rx_byte;
          state <= SPL_CNT_LO;
        end
        SPL_CNT_LO:
        begin
          remaining <= {count_hi, rx_byte}; // RULE1
          state <= ({count_hi, rx_byte} == 16'h0000) ? SPL_DONE : SPL_INSTR;
        end
        SPL_INSTR:
        begin
          case (byte_pos)
            2'h0:
            begin
              upper_word_assembly <= {rx_byte, 8'h00}; // RULE2
            end
            2'h1:
            begin
              upper_word_assembly <= {upper_word_assembly[15:8], rx_byte};
            end
            default:
            begin
              low_byte_holding_reg <= rx_byte;
              remaining <= remaining - 16'h0001; // RULE8
              if (remaining == 16'h0001)
                state <= SPL_DONE; // RULE10
            end
          endcase
        end
        SPL_DONE:
          state <= SPL_DONE;
        default:
          state <= SPL_CNT_HI;
      endcase
    end
  end
  // byte position inside an instruction
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      byte_pos <= 2'h0;
    else if (rx_done && state == SPL_INSTR)
    begin
      if (byte_pos == 2'h2)
        byte_pos <= 2'h0; // RULE13
      else
        byte_pos <= byte_pos + 2'h1;
    end
  end
  // write strobe registered the cycle after the third byte
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_PM_WE <= 1'b0;
      O_PM_ADDR <= 14'h0000;
      addr <= `SPL_CODE_START; // RULE12
    end
    else
    begin
      O_PM_WE <= write_now;
      if (write_now)
      begin
        O_PM_ADDR <= addr; // RULE9
        addr <= next_addr;
      end
    end
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_START <= 1'b0;
      O_DONE <= 1'b0;
    end
    else
    begin
      O_START <= (state == SPL_DONE) && !O_DONE; // RULE10
      O_DONE <= (state == SPL_DONE);
    end
  end
  assign O_START_ADDR = `SPL_CODE_START;
  assign O_PM_DATA = {upper_word_assembly, low_byte_holding_reg}; // RULE3
endmodule : spl_loader

// ==== design/spl_pkg.sv ====
// types for the serial program loader
package spl_pkg;
  typedef enum logic [1:0]
  {
    SPL_CNT_HI = 2'b00,
    SPL_CNT_LO = 2'b01,
    SPL_INSTR = 2'b10,
    SPL_DONE = 2'b11
  } spl_dev_state_t;
  typedef enum logic [1:0]
  {
    SPL_H_IDLE = 2'b00,
    SPL_H_LOAD = 2'b01,
    SPL_H_SHIFT = 2'b10,
    SPL_H_END = 2'b11
  } spl_host_state_t;
endpackage : spl_pkg

// ==== dv/spl_chk.sv ====
// assertions on the serial link and the program memory write side
`include "spl_defines.svh"
module spl_chk
(
  input wire logic I_CLK, // system clock
  input wire logic I_SYS_RST, // synchronous reset, high
  input wire logic sclk, // serial clock
  input wire logic rfs, // frame sync
  input wire logic dr, // serial data
  input wire logic O_PM_WE, // write strobe
  input wire logic [`SPL_ADDR_BITS-1:0] O_PM_ADDR, // write address
  input wire logic [`SPL_INSTR_BITS-1:0] O_PM_DATA, // write data
  input wire logic O_START, // start pulse
  input wire logic O_DONE // download finished
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`SPL_ADDR_BITS-1:0] exp_addr;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // next address that a write must use
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      exp_addr <= `SPL_CODE_START;
    else if (O_PM_WE)
      exp_addr <= O_PM_ADDR + 14'h0001;
  end
  vec_guard_a: assert property (O_PM_WE |-> O_PM_ADDR > `SPL_VECTOR_LAST)
    else $error("write into vector area");
  mon_guard_a: assert property (O_PM_WE |-> O_PM_ADDR >= `SPL_CODE_START)
    else $error("write into resident loader");
  addr_seq_a: assert property (O_PM_WE |-> O_PM_ADDR == exp_addr)
    else $error("write address not sequential");
  we_gap_a: assert property (O_PM_WE |=> !O_PM_WE [*8])
    else $error("writes too close together");
  start_once_a: assert property (O_START |=> !O_START)
    else $error("start pulse too long");
  start_done_a: assert property ($rose(O_DONE) |-> O_START)
    else $error("done without start");
  done_stop_a: assert property (O_DONE |=> O_DONE && !O_PM_WE)
    else $error("activity after done");
  sclk_rate_a: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock too fast");
  rfs_width_a: assert property ($rose(rfs) |-> rfs [*8] ##1 !rfs)
    else $error("frame sync width wrong");
  dr_edge_a: assert property ($changed(dr) |-> $fell(sclk))
    else $error("data changed off falling clock");
  rfs_edge_a: assert property ($changed(rfs) |-> $fell(sclk))
    else $error("frame sync changed off falling clock");
  data_hold_a: assert property (O_PM_WE |=> $stable(O_PM_DATA))
    else $error("write data moved after strobe");
  cover property (O_PM_WE);
  cover property ($rose(O_DONE));
  cover property ($rose(rfs));
  cover property (O_START);
endmodule : spl_chk

// ==== dv/tb_serial_program_loader.sv ====
// bench: host end and loader end joined over the serial link
`include "spl_defines.svh"
module tb_serial_program_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK, I_SYS_RST, I_VALID, O_READY, O_BUSY;
  logic [7:0] I_DATA;
  logic O_PM_WE, O_START, O_DONE;
  logic [`SPL_ADDR_BITS-1:0] O_PM_ADDR, O_START_ADDR;
  logic [`SPL_INSTR_BITS-1:0] O_PM_DATA;
  logic [23:0] img [3] = '{24'ha1b2c3, 24'h00ff10, 24'h5a0096};
  logic [7:0] sent [$];
  logic [7:0] sh;
  int fails = 0, checks = 0, n = 0, bc = -1, starts = 0;
  spl_link_if link ();
  spl_host spl_host_i (.I_CLK, .I_SYS_RST, .I_VALID, .I_DATA, .O_READY, .O_BUSY, .link(link));
  spl_loader spl_loader_i (.I_CLK, .I_SYS_RST, .link(link), .O_PM_WE, .O_PM_ADDR,
    .O_PM_DATA, .O_START, .O_START_ADDR, .O_DONE);
  spl_chk spl_chk_i (.I_CLK, .I_SYS_RST, .sclk(link.sclk), .rfs(link.rfs), .dr(link.dr),
    .O_PM_WE, .O_PM_ADDR, .O_PM_DATA, .O_START, .O_DONE);
  initial
  begin
    I_CLK = 0;
    forever #50 I_CLK = ~I_CLK;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task stop_test;
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // offer one byte and hold it until the host takes it
  task send(input logic [7:0] b);
    @(posedge I_CLK);
    I_VALID <= 1'b1;
    I_DATA <= b;
    sent.push_back(b);
    for (int k = 0; k < 200 && O_READY !== 1'b1; k++)
      @(negedge I_CLK);
    chk(O_READY, 1'b1);
    @(posedge I_CLK);
    I_VALID <= 1'b0;
    @(negedge I_CLK);
    chk(O_BUSY, 1'b1);
  endtask : send
  task wait_done;
    for (int k = 0; k < 400 && O_DONE !== 1'b1; k++)
      @(negedge I_CLK);
  endtask : wait_done
  // every program memory write against the image
  always @(posedge I_CLK)
  begin
    if (O_PM_WE === 1'b1)
    begin
      chk(O_PM_ADDR, `SPL_CODE_START + n);
      chk(O_PM_DATA, img[n]);
      n++;
    end
    if (O_START === 1'b1)
      starts++;
  end
  // bytes on the wire: frame sync one bit ahead, then msb first
  always @(posedge link.sclk)
  begin
    if (link.rfs === 1'b1)
      bc = 0;
    else if (bc >= 0)
    begin
      sh = {sh[6:0], link.dr};
      bc++;
      if (bc == 8)
      begin
        chk(sh, sent.pop_front());
        bc = -1;
      end
    end
  end
  task t_load;
    send(8'h00);
    send(8'h03);
    for (int i = 0; i < 3; i++)
    begin
      send(img[i][23:16]);
      send(img[i][15:8]);
      send(img[i][7:0]);
    end
    wait_done();
    repeat (2) @(negedge I_CLK);
    chk(n, 3);
    chk(O_DONE, 1'b1);
    chk(O_START_ADDR, `SPL_CODE_START);
    chk(starts, 1);
  endtask : t_load
  task t_after;
    send(8'h77);
    repeat (120) @(negedge I_CLK);
    chk(n, 3);
    chk(starts, 1);
  endtask : t_after
  task t_zero;
    @(posedge I_CLK);
    I_SYS_RST <= 1'b1;
    repeat (3) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    chk(O_DONE, 1'b0);
    n = 0;
    starts = 0;
    send(8'h00);
    send(8'h00);
    wait_done();
    repeat (2) @(negedge I_CLK);
    chk(O_DONE, 1'b1);
    chk(n, 0);
    chk(starts, 1);
  endtask : t_zero
  initial
  begin
    I_SYS_RST = 1'b1;
    I_VALID = 1'b0;
    I_DATA = 8'h00;
    repeat (3) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    t_load();
    t_after();
    t_zero();
    stop_test();
  end
  initial
  begin
    repeat (6000) @(posedge I_CLK);
    fails++;
    stop_test();
  end
endmodule : tb_serial_program_loader
